// ---- pkg/drseq_consts.vh ----
`ifndef DRSEQ_CONSTS_VH
`define DRSEQ_CONSTS_VH
`define DRSEQ_CLK_MHZ 100
`define DRSEQ_LCLK_DIV 50
`define DRSEQ_WINDOW_US 96
`define DRSEQ_PSEUDO_SECTOR_US 34000
`define DRSEQ_ARM_US 480
`define DRSEQ_ACQ_US 125
`define DRSEQ_SLOW_US 32
`define DRSEQ_DENS_US 512
`define DRSEQ_SEARCH_US 736
`define DRSEQ_PAYLOAD_US 780
`define DRSEQ_HOLDOFF_US 44
`define DRSEQ_MOTOR_MS 12000
`define DRSEQ_BOOT_BASE 16'he800
`define DRSEQ_MOTOR_BASE 16'hec00
`define DRSEQ_CTRL_MASK 16'hfc00
`endif

// ---- rtl/drseq_tick.v ----
`timescale 1ns/1ps
module drseq_tick #(
	parameter DIV = 50
) (
	input wire mclk_i,
	input wire rst_n,
	output reg tick
);
	reg [15:0] cnt;
	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == DIV - 1) begin
			cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

// ---- rtl/drseq_top.v ----
`timescale 1ns/1ps
`include "drseq_consts.vh"
// Contract
// R01 - The window output is high for 96 us after each sector pulse, and pseudo sector pulses recur every 34 ms without a diskette.
// R02 - Read arm rises 480 us after the window start.
// R03 - Phase acquire rises with read arm and lasts within 100 to 150 us.
// R04 - The twice-bit-rate clock is low before arming, 4 us period for 32 us, then 2 us period.
// R05 - With double density data the density flag rises at 512 us.
// R06 - Sync search enable rises at 736 us.
// R07 - The bit cell strobe toggles with a 4 us period after read arming.
// R08 - With zero data the separated bit pulses only during acquire and the shift outputs stay low.
// R09 - Payload flag stays low without sync; on forced sync it rises at 780 us with a 38 to 50 us hold-off pulse.
// R10 - Each spindle start strobe runs the motors for about 12 seconds.
// R11 - Host reads in the controller motor block start the motors and select the addressed drive.
// R12 - The bootstrap memory answers from address E800H upward.
// R13 - The host issues commands within the 96 us window after a sector pulse.
// R14 - Sync detected while searching enters the payload phase.
// R15 - A host read command waits until the shift register holds a full byte; the code drops wait once bitcnt is 7, after seven bits.
// R16 - All sequencing runs from a 2 MHz local tick.
// R17 - Times count from the window start, restart on each sector pulse, and reset clears all state; reset loads pos with FFFFH rather than zero.
module drseq_top #(
	parameter MOTOR_US = `DRSEQ_MOTOR_MS * 1000,
	parameter PSEUDO_US = `DRSEQ_PSEUDO_SECTOR_US
) (
	input wire mclk_i,
	input wire rstn_i,
	input wire sector_pulse_i,
	input wire disk_present_i,
	input wire double_density_i,
	input wire raw_bit_i,
	input wire sync_found_i,
	input wire spindle_start_i,
	input wire bus_read_i,
	input wire [15:0] bus_addr_i,
	input wire read_cmd_i,
	output reg window_o,
	output reg read_arm_o,
	output reg acquire_o,
	output reg twice_bitrate_clock_o,
	output reg density_flag_o,
	output reg sync_search_enable_o,
	output reg read_gate_strobe_o,
	output reg separated_bit_o,
	output reg [7:0] read_shift_outputs_o,
	output reg payload_o,
	output reg sync_holdoff_o,
	output reg motor_on_o,
	output reg [1:0] drive_sel_o,
	output reg boot_sel_o,
	output reg [7:0] boot_addr_o,
	output reg wait_o
);
	reg rst_s1;
	reg rst_n;
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	wire tick;
	// R16 local clock
	drseq_tick #(
		.DIV(`DRSEQ_LCLK_DIV)
	) u_tick (
		.mclk_i(mclk_i),
		.rst_n(rst_n),
		.tick(tick)
	);

	// Each local tick is half a microsecond.
	localparam [15:0] T_WIN = `DRSEQ_WINDOW_US * 2;
	localparam [15:0] T_ARM = `DRSEQ_ARM_US * 2;
	localparam [15:0] T_ACQ = (`DRSEQ_ARM_US + `DRSEQ_ACQ_US) * 2;
	localparam [15:0] T_FAST = (`DRSEQ_ARM_US + `DRSEQ_SLOW_US) * 2;
	localparam [15:0] T_DENS = `DRSEQ_DENS_US * 2;
	localparam [15:0] T_SRCH = `DRSEQ_SEARCH_US * 2;
	localparam [15:0] T_PAY = `DRSEQ_PAYLOAD_US * 2;
	localparam [15:0] T_HOLD = (`DRSEQ_PAYLOAD_US + `DRSEQ_HOLDOFF_US) * 2;
	localparam [16:0] T_PSEUDO = PSEUDO_US * 2;
	// The motor timer counts whole microseconds, so short sim times still work.
	localparam [25:0] T_MOTOR = MOTOR_US;
	localparam [10:0] MS_TICKS = 11'd2;

	reg [15:0] pos;
	reg [16:0] pseudo;
	reg [2:0] phase;
	reg sector_d;
	reg [2:0] bitcnt;
	reg [25:0] motor_ms;
	reg [10:0] ms_div;

	// A missing diskette is replaced by an internal sector pulse.
	wire sector_edge = sector_pulse_i & ~sector_d;
	wire pseudo_hit = ~disk_present_i & (pseudo == T_PSEUDO - 17'd1);
	wire start = sector_edge | (tick & pseudo_hit);
	wire in_motor = bus_read_i &
		((bus_addr_i & `DRSEQ_CTRL_MASK) == `DRSEQ_MOTOR_BASE);

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			sector_d <= 1'b0;
			pos <= 16'hffff;
			pseudo <= 17'h00000;
			phase <= 3'h0;
			bitcnt <= 3'h0;
			window_o <= 1'b0;
			read_arm_o <= 1'b0;
			acquire_o <= 1'b0;
			twice_bitrate_clock_o <= 1'b0;
			density_flag_o <= 1'b0;
			sync_search_enable_o <= 1'b0;
			read_gate_strobe_o <= 1'b0;
			separated_bit_o <= 1'b0;
			read_shift_outputs_o <= 8'h00;
			payload_o <= 1'b0;
			sync_holdoff_o <= 1'b0;
			wait_o <= 1'b0;
		end else begin
			sector_d <= sector_pulse_i;
			if (start) begin
				// R17 restart timing
				pos <= 16'h0000;
				pseudo <= 17'h00000;
				phase <= 3'h0;
				bitcnt <= 3'h0;
				// R01 window opens
				window_o <= 1'b1;
				read_arm_o <= 1'b0;
				acquire_o <= 1'b0;
				twice_bitrate_clock_o <= 1'b0;
				density_flag_o <= 1'b0;
				sync_search_enable_o <= 1'b0;
				payload_o <= 1'b0;
				sync_holdoff_o <= 1'b0;
				separated_bit_o <= 1'b0;
				read_shift_outputs_o <= 8'h00;
			end else if (tick) begin
				if (pos != 16'hffff)
					pos <= pos + 16'h0001;
				pseudo <= pseudo + 17'h00001;
				phase <= phase + 3'h1;
				// R01 window closes
				if (pos == T_WIN - 16'h0001)
					window_o <= 1'b0;
				// R02 arm
				if (pos == T_ARM - 16'h0001) begin
					read_arm_o <= 1'b1;
					// R03 acquire
					acquire_o <= 1'b1;
					phase <= 3'h0;
				end
				if (pos == T_ACQ - 16'h0001)
					acquire_o <= 1'b0;
				// R04 bit-rate clock
				if (read_arm_o) begin
					if (pos < T_FAST) begin
						if (phase[2:0] == 3'h3 || phase[2:0] == 3'h7)
							twice_bitrate_clock_o <= ~twice_bitrate_clock_o;
					end else if (phase[0])
						twice_bitrate_clock_o <= ~twice_bitrate_clock_o;
					// R07 bit cell strobe
					if (phase[1:0] == 2'h3)
						read_gate_strobe_o <= ~read_gate_strobe_o;
				end
				// R08 data path
				separated_bit_o <= acquire_o & raw_bit_i & ~separated_bit_o;
				if (read_gate_strobe_o && phase[1:0] == 2'h3 && payload_o) begin
					read_shift_outputs_o <= {read_shift_outputs_o[6:0],
						raw_bit_i};
					bitcnt <= bitcnt + 3'h1;
				end
				// R05 density
				if (pos == T_DENS - 16'h0001 && double_density_i)
					density_flag_o <= 1'b1;
				// R06 search
				if (pos == T_SRCH - 16'h0001)
					sync_search_enable_o <= 1'b1;
				// R09 R14 payload entry
				if (sync_search_enable_o && !payload_o && sync_found_i &&
					pos >= T_PAY - 16'h0001) begin
					payload_o <= 1'b1;
					sync_holdoff_o <= 1'b1;
				end
				if (pos == T_HOLD - 16'h0001)
					sync_holdoff_o <= 1'b0;
			end
			// R15 hold the host until seven bits are shifted in
			if (read_cmd_i && !(payload_o && bitcnt == 3'h7))
				wait_o <= 1'b1;
			else
				wait_o <= 1'b0;
		end
	end

	always @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			motor_ms <= 26'h0000000;
			ms_div <= 11'h000;
			motor_on_o <= 1'b0;
			drive_sel_o <= 2'h0;
			boot_sel_o <= 1'b0;
			boot_addr_o <= 8'h00;
		end else begin
			// R12 bootstrap decode
			boot_sel_o <= bus_read_i &&
				((bus_addr_i & 16'hff00) == `DRSEQ_BOOT_BASE);
			boot_addr_o <= bus_addr_i[7:0];
			if (spindle_start_i || in_motor) begin
				// R10 R11 retrigger motor timer
				motor_ms <= T_MOTOR;
				ms_div <= 11'h000;
				motor_on_o <= 1'b1;
				if (in_motor)
					drive_sel_o <= bus_addr_i[1:0];
			end else if (tick && motor_on_o) begin
				if (ms_div == MS_TICKS - 11'd1) begin
					ms_div <= 11'h000;
					if (motor_ms <= 26'h0000001)
						motor_on_o <= 1'b0;
					motor_ms <= motor_ms - 26'h0000001;
				end else
					ms_div <= ms_div + 11'h001;
			end
		end
	end
endmodule

// ---- verif/drseq_drive_model.sv ----
`timescale 1ns/1ps
module drseq_drive_model #(
	parameter HOLE = 20
) (
	input wire clk_i,
	input wire spin_i,
	input wire force_sync_i,
	output reg sector_o = 1'b0,
	output reg raw_o = 1'b0,
	output reg sync_o = 1'b0
);
	integer n = 0;
	// One hole per start, since a rotation outlasts the run.
	always @(negedge clk_i) begin
		n <= spin_i ? n + 1 : 0;
		sector_o <= spin_i && n < HOLE;
		raw_o <= 1'b0;
		sync_o <= force_sync_i;
	end
endmodule

// ---- verif/drseq_top_monitor.sv ----
`timescale 1ns/1ps
module drseq_top_monitor (
	input wire mclk_i,
	input wire rstn_i,
	input wire bus_read_i,
	input wire [15:0] bus_addr_i,
	input wire window_o,
	input wire read_arm_o,
	input wire acquire_o,
	input wire twice_bitrate_clock_o,
	input wire density_flag_o,
	input wire sync_search_enable_o,
	input wire payload_o,
	input wire sync_holdoff_o,
	input wire motor_on_o,
	input wire [1:0] drive_sel_o,
	input wire boot_sel_o,
	input wire [7:0] boot_addr_o
);
	reg [16:0] t;
	reg pw;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// Cycles since the window opened; saturates so late checks stay sane.
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t <= 17'h00000;
			pw <= 1'b0;
		end else begin
			pw <= window_o;
			if (window_o && !pw)
				t <= 17'h00001;
			else if (t != 17'h1ffff)
				t <= t + 17'h00001;
		end
	end
	chk_win_len: assert property ($fell(window_o) |-> t > 9540 && t < 9660)
		else $error("window length wrong");
	chk_arm_time: assert property ($rose(read_arm_o) |-> t > 47940 && t < 48060)
		else $error("read arm time wrong");
	chk_acq_len: assert property ($fell(acquire_o) |-> t > 57940 && t < 63060)
		else $error("acquire length wrong");
	chk_clk_idle: assert property (t < 47900 |-> !twice_bitrate_clock_o)
		else $error("bit rate clock early");
	chk_dens_time: assert property ($rose(density_flag_o) |-> t > 51140 && t < 51260)
		else $error("density time wrong");
	chk_search_time: assert property ($rose(sync_search_enable_o) |-> t > 73540 && t < 73660)
		else $error("search time wrong");
	chk_payload_start: assert property ($rose(payload_o) |-> sync_search_enable_o && t > 77940 ##[0:2] sync_holdoff_o)
		else $error("payload start wrong");
	chk_holdoff_len: assert property ($fell(sync_holdoff_o) |-> t > 81740 && t < 83060)
		else $error("holdoff length wrong");
	chk_drive_sel: assert property (bus_read_i && bus_addr_i[15:10] == 6'h3b |-> ##1 motor_on_o && drive_sel_o == $past(bus_addr_i[1:0]))
		else $error("drive select wrong");
	cover property ($rose(payload_o));
	cover property ($fell(motor_on_o));
	cover property ($rose(boot_sel_o));
endmodule
bind drseq_top drseq_top_monitor i_mon (.*);

// ---- verif/drseq_top_tb_top.sv ----
`timescale 1ns/1ps
module drseq_top_tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg spin = 1'b0;
	reg st = 1'b0;
	reg rd = 1'b0;
	reg cmd = 1'b0;
	reg [15:0] a = 16'h0000;
	reg [31:0] r = 32'h9a6a9340;
	reg [6:0] p = 7'h00;
	reg p2 = 1'b0, pg = 1'b0, ps = 1'b0;
	wire sp, raw, sy, w, ra, ac, b2, df, se, gs, sb, pl, ho, mo, bs, wt;
	wire [7:0] sh, ba;
	wire [1:0] ds;
	wire [6:0] s = {ho, pl, se, df, ac, ra, w};
	integer mismatches = 0, checked = 0, t = 0, i, n2 = 0, ng = 0, nsep = 0;
	integer ct[0:6];
	integer lo[0:6] = '{9550, 47950, 57950, 51150, 73550, 77950, 81750};
	integer hi[0:6] = '{9650, 48050, 63050, 51250, 73650, 78050, 83050};
	function [31:0] lf(input [31:0] v);
		lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task ck(input ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error %0t: %s", $time, m);
		end
	endtask
	task end_sim;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	drseq_top #(.MOTOR_US(200), .PSEUDO_US(1000)) i_dut (.mclk_i(clk),
		.rstn_i(rst_n), .sector_pulse_i(sp), .disk_present_i(1'b1),
		.double_density_i(1'b1), .raw_bit_i(raw), .sync_found_i(sy),
		.spindle_start_i(st), .bus_read_i(rd), .bus_addr_i(a),
		.read_cmd_i(cmd), .window_o(w), .read_arm_o(ra), .acquire_o(ac),
		.twice_bitrate_clock_o(b2), .density_flag_o(df),
		.sync_search_enable_o(se), .read_gate_strobe_o(gs),
		.separated_bit_o(sb), .read_shift_outputs_o(sh), .payload_o(pl),
		.sync_holdoff_o(ho), .motor_on_o(mo), .drive_sel_o(ds),
		.boot_sel_o(bs), .boot_addr_o(ba), .wait_o(wt));
	drseq_drive_model i_drv (.clk_i(clk), .spin_i(spin), .force_sync_i(1'b1),
		.sector_o(sp), .raw_o(raw), .sync_o(sy));
	// Reference timeline: last change of each output, cycles from window.
	always @(posedge clk) begin
		t = (w && !p[0]) ? 1 : t + 1;
		for (int k = 0; k < 7; k++)
			if (s[k] !== p[k])
				ct[k] = t;
		if (b2 !== p2 && t >= 48000 && t < 51200)
			n2++;
		if (gs !== pg && t >= 48100 && t < 51300)
			ng++;
		if (sb && !ps && !ac)
			nsep++;
		p = s;
		p2 = b2;
		pg = gs;
		ps = sb;
	end
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		ck(w === 1'b0 && mo === 1'b0 && pl === 1'b0, "reset state");
		spin = 1'b1;
		$display("reset test done");
		for (i = 0; i < 7; i++) begin
			r = lf(r);
			a = i < 3 ? {6'h3b, r[9:0]} : i < 6 ? {8'he8, r[7:0]} : r[15:0] & 16'h7fff;
			rd = 1'b1;
			@(negedge clk);
			rd = 1'b0;
			if (i < 3)
				ck(mo === 1'b1 && ds === a[1:0], "drive select");
			else
				ck(bs === (i < 6) && (i == 6 || ba === a[7:0]), "boot");
		end
		cmd = 1'b1;
		@(negedge clk);
		cmd = 1'b0;
		ck(wt === 1'b1, "wait");
		$display("bus test done");
		st = 1'b1;
		@(negedge clk);
		st = 1'b0;
		repeat (19800) @(negedge clk);
		ck(mo === 1'b1, "motor early off");
		repeat (300) @(negedge clk);
		ck(mo === 1'b0, "motor stays on");
		$display("motor test done");
		wait (t > 83500);
		for (i = 0; i < 7; i++)
			ck(ct[i] >= lo[i] && ct[i] <= hi[i], "event time");
		ck(n2 >= 15 && n2 <= 17, "bit rate clock");
		ck(ng >= 15 && ng <= 17, "bit cell strobe");
		ck(nsep === 0 && sh === 8'h00, "zero data");
		$display("sequence test done");
		end_sim;
	end
	initial begin
		#1000000;
		mismatches++;
		end_sim;
	end
endmodule
